// ==== include/alarm_map.svh ====
// Register offsets, field positions, reset values and timing for the alarms
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_SP0         8'h04
`define OFS_SP1         8'h08
`define OFS_HYS0        8'h0c
`define OFS_HYS1        8'h10
`define OFS_ON0         8'h14
`define OFS_OFF0        8'h18
`define OFS_ON1         8'h1c
`define OFS_OFF1        8'h20
`define OFS_STATUS      8'h24
`define OFS_IRQ_STAT    8'h28
`define OFS_IRQ_MASK    8'h2c
`define OFS_VALUE       8'h30

// ==========================================================================
// Control field positions
`define CTRL_DIR_LSB    0
`define CTRL_POL_LSB    2
`define CTRL_BURN_LSB   4

// ==========================================================================
// Reset values (per channel: bit 0 is channel one)
`define DIR_RST         2'h1
`define POL_RST         2'h3
`define SP0_RST         10'h3e8
`define SP1_RST         10'h000
`define HYS_RST         10'h01e
`define DELAY_RST       10'h000
`define MASK_RST        5'h00

// ==========================================================================
// Ranges, in 0.1 % steps and seconds
`define PCT_FULL        10'h3e8
`define DELAY_MAX       10'h3e7

// ==========================================================================
// Timing
`define CLK_HZ          25000000
`define TICK_MS         100
`define MARGIN_MS       200
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_S     (1000 / `TICK_MS)
`define MARGIN_TICKS    ((`MARGIN_MS + `TICK_MS - 1) / `TICK_MS)

`endif

// ==== include/alarm_pkg.sv ====
// Types shared by the dual limit alarm
package alarm_pkg;

    // ======================================================================
    // Value and setting types
    typedef logic [9:0]  pct_t;
    typedef logic [9:0]  delay_t;
    typedef logic [13:0] ticks_t;

    // ======================================================================
    // Burnout action on input break
    typedef enum logic [1:0] {
        BURN_OFF,
        BURN_UP,
        BURN_DOWN
    } burnout_t;

endpackage

// ==== logic/dual_limit_alarm.sv ====
// Two limit alarms with hysteresis, delays, relay polarity and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

// Functional notes
// - Two channels, each drives one relay contact
// - Each channel selects high or low limit
// - Polarity picks relay state during normal status
// - Setpoint 0 to 100 % in 0.1 % steps
// - Hysteresis 0 to 100 % in 0.1 % steps
// - Alarm after condition holds for on-delay
// - Release after normal holds for off-delay
// - Both delays get about 0.2 s extra
// - Each channel lights its own alarm lamp
// - Zero delays: output changes within 350 ms
// - Input break drives value up, down or not
// - Reset: channel one high, channel two low
// - Reset: relays energize during alarm
// - Reset: setpoints 100 % and 0 %
// - Reset: hysteresis 3 % on both channels
// - Reset: all delays zero seconds
module dual_limit_alarm #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire alarm_pkg::pct_t pv_value,
    input  wire logic          input_break,
    output logic               first_alarm_contact,
    output logic               second_alarm_contact,
    output logic               first_alarm_lamp,
    output logic               second_alarm_lamp,
    output logic               irq
);
    import alarm_pkg::*;

    // ======================================================================
    // Helpers
    function automatic pct_t clamp_set(input logic [31:0] d,
                                       input pct_t lim);
        if (d > {22'h00_0000, lim})
            return lim;
        return d[9:0];
    endfunction

    function automatic ticks_t delay_ticks(input delay_t d);
        logic [31:0] t;
        t = 32'(d) * 32'(`TICKS_PER_S) + 32'(`MARGIN_TICKS);
        return t[13:0];
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `OFS_VALUE);
    endfunction

    // ======================================================================
    // State
    logic [1:0]  dir;           // 1 = high limit
    logic [1:0]  pol;           // 1 = energize during alarm
    burnout_t    burn_mode;
    pct_t        sp      [2];
    pct_t        hys     [2];
    delay_t      on_dly  [2];
    delay_t      off_dly [2];
    logic [1:0]  cond;
    logic [1:0]  alarm;
    logic [1:0]  alarm_prev;
    ticks_t      cnt     [2];
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic        brk_meta;
    logic        brk_sync;
    logic        brk_prev;
    logic [21:0] div_cnt;
    logic        tick;
    pct_t        value_eff;
    logic [1:0]  trip;
    logic [1:0]  clr;
    ticks_t      target  [2];
    logic [31:0] rd_word;
    logic        wr_en;
    logic [4:0]  events;
    logic [23:0] fast_wait;

    assign wr_en = psel && penable && pready && pwrite;

    // ======================================================================
    // APB handshake: one wait state, so every output is registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !addr_ok(paddr);
            prdata  <= addr_ok(paddr) ? rd_word : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `OFS_CTRL:     rd_word = {26'h000_0000, burn_mode, pol, dir};
            `OFS_SP0:      rd_word = {22'h00_0000, sp[0]};
            `OFS_SP1:      rd_word = {22'h00_0000, sp[1]};
            `OFS_HYS0:     rd_word = {22'h00_0000, hys[0]};
            `OFS_HYS1:     rd_word = {22'h00_0000, hys[1]};
            `OFS_ON0:      rd_word = {22'h00_0000, on_dly[0]};
            `OFS_OFF0:     rd_word = {22'h00_0000, off_dly[0]};
            `OFS_ON1:      rd_word = {22'h00_0000, on_dly[1]};
            `OFS_OFF1:     rd_word = {22'h00_0000, off_dly[1]};
            `OFS_STATUS:   rd_word = {26'h000_0000, burn_mode != BURN_OFF
                                      && brk_sync, brk_sync, cond, alarm};
            `OFS_IRQ_STAT: rd_word = {27'h000_0000, irq_stat};
            `OFS_IRQ_MASK: rd_word = {27'h000_0000, irq_mask};
            `OFS_VALUE:    rd_word = {22'h00_0000, value_eff};
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // Configuration registers; writes beyond range clamp to the maximum
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir        <= `DIR_RST;
            pol        <= `POL_RST;
            burn_mode  <= BURN_OFF;
            sp[0]      <= `SP0_RST;
            sp[1]      <= `SP1_RST;
            hys[0]     <= `HYS_RST;
            hys[1]     <= `HYS_RST;
            on_dly[0]  <= `DELAY_RST;
            on_dly[1]  <= `DELAY_RST;
            off_dly[0] <= `DELAY_RST;
            off_dly[1] <= `DELAY_RST;
            irq_mask   <= `MASK_RST;
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_CTRL: begin
                    dir <= pwdata[`CTRL_DIR_LSB +: 2];
                    pol <= pwdata[`CTRL_POL_LSB +: 2];
                    // Unknown code 3 falls back to no action
                    if (pwdata[`CTRL_BURN_LSB +: 2] == 2'h1)
                        burn_mode <= BURN_UP;
                    else if (pwdata[`CTRL_BURN_LSB +: 2] == 2'h2)
                        burn_mode <= BURN_DOWN;
                    else
                        burn_mode <= BURN_OFF;
                end
                `OFS_SP0:  sp[0]      <= clamp_set(pwdata, `PCT_FULL);
                `OFS_SP1:  sp[1]      <= clamp_set(pwdata, `PCT_FULL);
                `OFS_HYS0: hys[0]     <= clamp_set(pwdata, `PCT_FULL);
                `OFS_HYS1: hys[1]     <= clamp_set(pwdata, `PCT_FULL);
                `OFS_ON0:  on_dly[0]  <= clamp_set(pwdata, `DELAY_MAX);
                `OFS_OFF0: off_dly[0] <= clamp_set(pwdata, `DELAY_MAX);
                `OFS_ON1:  on_dly[1]  <= clamp_set(pwdata, `DELAY_MAX);
                `OFS_OFF1: off_dly[1] <= clamp_set(pwdata, `DELAY_MAX);
                `OFS_IRQ_MASK: irq_mask <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Break input synchroniser; only brk_sync feeds logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brk_meta <= 1'b0;
            brk_sync <= 1'b0;
            brk_prev <= 1'b0;
        end else begin
            brk_meta <= input_break;
            brk_sync <= brk_meta;
            brk_prev <= brk_sync;
        end
    end

    // Burnout forces the value at once, well inside the allowed time
    always_comb begin
        value_eff = pv_value;
        if (brk_sync && burn_mode == BURN_UP)
            value_eff = `PCT_FULL;
        else if (brk_sync && burn_mode == BURN_DOWN)
            value_eff = 10'h000;
    end

    // ======================================================================
    // 100 ms time base; delays count in these ticks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= 22'h00_0000;
            tick    <= 1'b0;
        end else if (div_cnt == 22'(TICK_CYCLES - 1)) begin
            div_cnt <= 22'h00_0000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 22'h00_0001;
            tick    <= 1'b0;
        end
    end

    // ======================================================================
    // Limit compare with hysteresis band
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (dir[i]) begin
                trip[i] = value_eff > sp[i];
                clr[i]  = ({1'b0, value_eff} + {1'b0, hys[i]})
                          < {1'b0, sp[i]};
            end else begin
                trip[i] = value_eff < sp[i];
                clr[i]  = {1'b0, value_eff}
                          > ({1'b0, sp[i]} + {1'b0, hys[i]});
            end
            target[i] = alarm[i] ? delay_ticks(off_dly[i])
                                 : delay_ticks(on_dly[i]);
        end
    end

    // Raw condition holds inside the band
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cond <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (trip[i])
                    cond[i] <= 1'b1;
                else if (clr[i])
                    cond[i] <= 1'b0;
            end
        end
    end

    // On and off delay; a lapse restarts the count from zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm  <= 2'h0;
            cnt[0] <= 14'h0000;
            cnt[1] <= 14'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cond[i] == alarm[i]) begin
                    cnt[i] <= 14'h0000;
                end else if (tick) begin
                    if (cnt[i] + 14'h0001 >= target[i]) begin
                        alarm[i] <= cond[i];
                        cnt[i]   <= 14'h0000;
                    end else begin
                        cnt[i] <= cnt[i] + 14'h0001;
                    end
                end
            end
        end
    end

    // ======================================================================
    // Contacts and lamps, registered straight to the pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            first_alarm_contact  <= 1'b0;
            second_alarm_contact <= 1'b0;
            first_alarm_lamp     <= 1'b0;
            second_alarm_lamp    <= 1'b0;
        end else begin
            first_alarm_contact  <= pol[0] ? alarm[0] : !alarm[0];
            second_alarm_contact <= pol[1] ? alarm[1] : !alarm[1];
            first_alarm_lamp     <= alarm[0];
            second_alarm_lamp    <= alarm[1];
        end
    end

    // ======================================================================
    // Interrupts: set wins over a same-cycle write-one-to-clear
    assign events = {brk_sync && !brk_prev,
                     alarm_prev & ~alarm,
                     alarm & ~alarm_prev};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm_prev <= 2'h0;
            irq_stat   <= 5'h00;
            irq        <= 1'b0;
        end else begin
            alarm_prev <= alarm;
            if (wr_en && paddr == `OFS_IRQ_STAT)
                irq_stat <= (irq_stat & ~pwdata[4:0]) | events;
            else
                irq_stat <= irq_stat | events;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    reset_defaults_a: assert property (disable iff (1'b0)
        sys_rst |=> dir == 2'h1 && pol == 2'h3 && sp[0] == 10'h3e8
                 && sp[1] == 10'h000 && hys[0] == 10'h01e
                 && hys[1] == 10'h01e && on_dly[0] == 10'h000
                 && on_dly[1] == 10'h000 && off_dly[0] == 10'h000
                 && off_dly[1] == 10'h000)
        else $error("configuration not at factory values after reset");
    // are covered by the same check above

    setpoint_range_a: assert property (sp[0] <= 10'h3e8
                                       && sp[1] <= 10'h3e8
                                       && hys[0] <= 10'h3e8
                                       && hys[1] <= 10'h3e8)
        else $error("setpoint or hysteresis above full range");

    high_trip_a: assert property (
        dir[0] && value_eff > sp[0] |=> cond[0])
        else $error("high limit did not trip above setpoint");

    band_hold_a: assert property (
        cond[0] && dir[0] && !trip[0]
        && ({1'b0, value_eff} + {1'b0, hys[0]}) >= {1'b0, sp[0]}
        |=> cond[0])
        else $error("condition cleared inside hysteresis band");

    on_delay_a: assert property (
        $rose(alarm[0]) |-> $past(cnt[0]) + 14'h0001
                            >= delay_ticks($past(on_dly[0])))
        else $error("alarm entered before on-delay elapsed");

    lapse_restart_a: assert property (
        !alarm[0] && !cond[0] |=> cnt[0] == 14'h0000)
        else $error("delay count kept after condition lapsed");

    // Cycles spent waiting to enter a zero-delay alarm; the bound is
    // 3.5 ticks, so it scales with the short tick used in simulation
    always_ff @(posedge clk) begin
        if (sys_rst || alarm[0] || !cond[0] || on_dly[0] != 10'h000)
            fast_wait <= 24'h00_0000;
        else
            fast_wait <= fast_wait + 24'h00_0001;
    end

    fast_alarm_a: assert property (
        fast_wait < 24'((TICK_CYCLES * 35) / 10))
        else $error("zero-delay alarm slower than expected");

    contact_pol_a: assert property (
        ##1 first_alarm_contact == ($past(pol[0]) ? $past(alarm[0])
                                                  : !$past(alarm[0])))
        else $error("relay contact disagrees with polarity");

    lamp_follow_a: assert property (
        $rose(alarm[1]) |=> second_alarm_lamp ##1 second_alarm_lamp
                            || !alarm[1])
        else $error("lamp not lit while in alarm");

    burnout_up_a: assert property (
        brk_sync && burn_mode == BURN_UP |-> value_eff == 10'h3e8)
        else $error("burnout did not drive value upscale");

    irq_level_a: assert property (
        |(irq_stat & irq_mask) |=> irq)
        else $error("interrupt not raised for unmasked status");

    alarm_enter_c:  cover property ($rose(alarm[0]));
    alarm_low_c:    cover property ($rose(alarm[1]) && !dir[1]);
    alarm_release_c: cover property ($fell(alarm[0]) ##[1:20] $rose(alarm[0]));
    burnout_down_c: cover property (brk_sync && burn_mode == BURN_DOWN);

endmodule
`default_nettype wire

// ==== bench/alarm_circuit.sv ====
// Model of the external circuit wired to the two relay contacts
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Contact loops
module alarm_circuit (
    input  wire logic       first_alarm_contact,
    input  wire logic       second_alarm_contact,
    output logic [1:0]      loop_closed
);
    // Normally open contacts, closed only while energized; one shared
    // return, so each loop simply follows its own relay drive
    assign loop_closed = {second_alarm_contact, first_alarm_contact};
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the dual limit alarm
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"
// ==========================================================================
// Bench top
module testbench;
    import alarm_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    pct_t        pv_value = 10'h000;
    logic        input_break = 1'b0;
    logic        lamp0;
    logic        lamp1;
    logic        irq;
    wire  [1:0]  drive;
    logic [1:0]  loop_closed;
    logic [32:0] notes[$];
    int          failures = 0;
    int          cmp_count = 0;
    int          n;
    logic [7:0]  ra[10] = '{`OFS_CTRL, `OFS_SP0, `OFS_SP1, `OFS_HYS0,
        `OFS_HYS1, `OFS_ON0, `OFS_OFF0, `OFS_ON1, `OFS_OFF1, `OFS_IRQ_MASK};
    logic [31:0] rv[10] = '{32'h0000_000d, 32'h0000_03e8, 32'h0000_0000,
        32'h0000_001e, 32'h0000_001e, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] bm[3] = '{32'h0000_001d, 32'h0000_002d, 32'h0000_000d};
    logic [31:0] bv[3] = '{32'h0000_03e8, 32'h0000_0000, 32'h0000_012c};

    // Short tick so second-scale delays run in about a hundred cycles
    dual_limit_alarm #(.TICK_CYCLES(10)) DUT (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pv_value(pv_value),
        .input_break(input_break), .first_alarm_contact(drive[0]),
        .second_alarm_contact(drive[1]), .first_alarm_lamp(lamp0),
        .second_alarm_lamp(lamp1), .irq(irq));

    alarm_circuit far_side (
        .first_alarm_contact(drive[0]),
        .second_alarm_contact(drive[1]),
        .loop_closed(loop_closed));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic check(input string nm, input logic [32:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // APB transfer; request held until pready is sampled at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, logic [31:0] e, logic er = 0);
        notes.push_back({er, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic put(input int v);
        @(posedge clk);
        pv_value <= 10'(v);
    endtask

    // Bounded wait for a contact loop to reach a level
    task automatic wait_pin(input int ch, logic v, int lim, output int k);
        k = 0;
        while (loop_closed[ch] !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask

    // Step the value and check the switching time lies in a window
    task automatic step(input int v, ch, logic want, int lo, int hi);
        put(v);
        wait_pin(ch, want, hi + 1, n);
        check("switch time", n >= lo && n <= hi, 1'b1);
    endtask

    // Read answers taken at the edge that samples pready, oldest note first
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                check("note queue", 1'b0, 1'b1);
            end else begin
                check("read", {pslverr, prdata}, notes.pop_front());
            end
        end
    end

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        void'($urandom(28));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        // In range values never trip the factory limits
        repeat (40) put($urandom_range(1000));
        @(negedge clk);
        check("contacts", {loop_closed, lamp1, lamp0}, 4'h0);
        // Full scale trips neither channel while settings change
        put(1000);
        for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
        // Unmapped and misaligned places are refused
        wr(8'h34, 32'h0000_ffff);
        rd(8'h34, 32'h0000_0000, 1'b1);
        rd(8'h06, 32'h0000_0000, 1'b1);
        wr(`OFS_SP0, 32'h0000_ffff);
        rd(`OFS_SP0, 32'h0000_03e8);
        wr(`OFS_HYS1, 32'h0000_07ff);
        rd(`OFS_HYS1, 32'h0000_03e8);
        wr(`OFS_ON0, 32'h0000_03ff);
        rd(`OFS_ON0, 32'h0000_03e7);
        for (int i = 0; i < 3; i++) begin
            n = $urandom_range(1000);
            wr(`OFS_SP1, 32'(n));
            rd(`OFS_SP1, 32'(n));
        end
        // Outside both bands once the new setpoints land
        put(300);
        wr(`OFS_SP1, 32'h0000_00c8);
        wr(`OFS_HYS1, 32'h0000_001e);
        wr(`OFS_ON0, 32'h0000_0000);
        wr(`OFS_SP0, 32'h0000_01f4);
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        // High limit, zero delays, 30 to 90 % across 50 %
        step(900, 0, 1'b1, 8, 26);
        check("lamp0", lamp0, 1'b1);
        repeat (3) @(negedge clk);
        check("irq", irq, 1'b1);
        rd(`OFS_IRQ_STAT, 32'h0000_0001);
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        wr(`OFS_IRQ_MASK, 32'h0000_0000);
        check("irq", irq, 1'b0);
        // Inside the band the alarm holds, below it releases
        put(480);
        wait_pin(0, 1'b0, 30, n);
        check("hold", n, 30);
        step(460, 0, 1'b0, 8, 26);
        check("irq", irq, 1'b0);
        // Low limit on the second channel
        step(150, 1, 1'b1, 8, 26);
        check("lamp1", lamp1, 1'b1);
        put(220);
        wait_pin(1, 1'b0, 30, n);
        check("hold", n, 30);
        step(300, 1, 1'b0, 8, 26);
        // Energized in normal status, dropped in alarm
        wr(`OFS_CTRL, 32'h0000_0009);
        wait_pin(0, 1'b1, 10, n);
        check("polarity", n < 10, 1'b1);
        step(900, 0, 1'b0, 8, 26);
        check("lamp0", lamp0, 1'b1);
        wr(`OFS_CTRL, 32'h0000_000d);
        // Contact must close first, or the release below proves nothing
        wait_pin(0, 1'b1, 10, n);
        check("polarity", n < 10, 1'b1);
        step(300, 0, 1'b0, 8, 26);
        // One second delays; a short lapse restarts the on timer
        wr(`OFS_ON0, 32'h0000_0001);
        wr(`OFS_OFF0, 32'h0000_0001);
        put(900);
        repeat (80) @(posedge clk);
        put(300);
        repeat (3) @(posedge clk);
        step(900, 0, 1'b1, 105, 128);
        step(300, 0, 1'b0, 105, 128);
        wr(`OFS_ON0, 32'h0000_0000);
        wr(`OFS_OFF0, 32'h0000_0000);
        // Burnout modes on an input break
        input_break <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTRL, bm[i]);
            repeat (10) @(posedge clk);
            rd(`OFS_VALUE, bv[i]);
        end
        input_break <= 1'b0;
        repeat (5) @(posedge clk);
        check("queue empty", notes.size() == 0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
